// ==== hw/mspe_byte_mux.sv ====
// byte picker: selects one byte of the nine captured words, lsb first
`timescale 1ns/1ps
module mspe_byte_mux (
   input wire logic [31:0] word_in [mspe_pkg::MSPE_MAX_FIELDS], // captured field words
   input wire logic [5:0] byte_index, // payload byte offset
   output logic [7:0] byte_out // selected byte
);
   import mspe_pkg::*;
   logic [3:0] word_sel; // which float word
   logic [1:0] lane_sel; // which byte inside it
   // offset splits into word and lane, lane 0 is least significant
   always_comb begin
      word_sel = byte_index[5:2];
      lane_sel = byte_index[1:0];
      byte_out = 8'h00;
      if (word_sel < 4'(MSPE_MAX_FIELDS)) begin
         byte_out = word_in[word_sel][8*lane_sel +: 8];
      end
   end
endmodule

// ==== hw/mspe_encoder.sv ====
// motion-state packet encoder: snapshots field words and streams the payload bytes
`timescale 1ns/1ps
// Overview of operation
// - velocity packet 35, north east down floats
// - body velocity packet 36, X Y Z
// - acceleration packet 37, X Y Z
// - packet 37 carries gravity included
// - body acceleration 38, XYZ plus g force
// - packet 38 carries gravity removed
// - Euler packet 39, roll pitch heading
// - quaternion packet 40, scalar then XYZ
// - matrix packet 41, nine floats row major
// - angular velocity packet 42, X Y Z
// - angular acceleration packet 43, X Y Z
// payload bytes leave on a valid/ready port, one per accepted handshake
module mspe_encoder (
   input wire logic clk, // 50 MHz system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic start, // request one packet, taken while idle
   input wire mspe_pkg::mspe_kind_t kind, // packet kind to build
   input wire logic [31:0] field_word [mspe_pkg::MSPE_MAX_FIELDS], // source floats in order
   input wire logic host_write, // host delivers a packet for writing
   input wire logic [7:0] host_write_id, // identifier of that packet
   input wire logic out_ready, // sink accepts a byte
   output logic busy, // packet in progress
   output logic [7:0] pkt_id, // identifier of current packet
   output logic [7:0] pkt_len, // payload length of current packet
   output logic out_valid, // payload byte available
   output logic [7:0] out_data, // payload byte
   output logic out_last, // final payload byte
   output logic write_reject // pulse: refused write to a read-only id
);
   import mspe_pkg::*;

   // framer states
   typedef enum logic [1:0] {
      MSPE_IDLE = 2'b00, // waiting for a request
      MSPE_SEND = 2'b01 // presenting bytes
   } mspe_state_t;

   mspe_state_t state, next_state; // framer state
   logic [31:0] snap [MSPE_MAX_FIELDS]; // field snapshot, frozen for the packet
   logic [31:0] next_snap [MSPE_MAX_FIELDS]; // next snapshot
   logic [5:0] byte_idx, next_byte_idx; // current payload offset
   logic [7:0] next_pkt_id, next_pkt_len; // header values
   logic next_busy, next_out_valid, next_out_last; // output next values
   logic [7:0] next_out_data; // next byte
   logic next_write_reject; // next reject pulse
   logic [7:0] mux_byte; // byte at the next offset
   logic [5:0] fetch_idx; // offset handed to the picker
   logic [7:0] sel_id, sel_len; // id and length for requested kind
   logic do_capture; // request taken this cycle
   logic [31:0] pick_src [MSPE_MAX_FIELDS]; // words the picker reads this cycle

   // identifier and length per kind; the source drives fields in payload order,
   // gravity included for 37 and removed for 38 is the source's arrangement
   // the framer never alters a word, it only orders and slices them
   always_comb begin
      // defaults also cover the unused kind codes 9 to 15
      sel_id = MSPE_ID_NORTH_EAST_DOWN_FRAME_VEL;
      sel_len = MSPE_LEN_3F;
      case (kind)
         MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL: begin
            sel_id = MSPE_ID_NORTH_EAST_DOWN_FRAME_VEL;
            sel_len = MSPE_LEN_3F;
         end
         MSPE_KIND_BODY_VEL: begin
            sel_id = MSPE_ID_BODY_VEL;
            sel_len = MSPE_LEN_3F;
         end
         MSPE_KIND_ACCEL: begin
            sel_id = MSPE_ID_ACCEL;
            sel_len = MSPE_LEN_3F;
         end
         MSPE_KIND_BODY_ACCEL: begin
            sel_id = MSPE_ID_BODY_ACCEL;
            sel_len = MSPE_LEN_4F;
         end
         MSPE_KIND_EULER: begin
            sel_id = MSPE_ID_EULER;
            sel_len = MSPE_LEN_3F;
         end
         MSPE_KIND_QUAT: begin
            sel_id = MSPE_ID_QUAT;
            sel_len = MSPE_LEN_4F;
         end
         MSPE_KIND_DIRECTION_COSINE_MATRIX: begin
            // nine words, the only payload that reaches the last snapshot word
            sel_id = MSPE_ID_DIRECTION_COSINE_MATRIX;
            sel_len = MSPE_LEN_9F;
         end
         MSPE_KIND_ANG_VEL: begin
            sel_id = MSPE_ID_ANG_VEL;
            sel_len = MSPE_LEN_3F;
         end
         MSPE_KIND_ANG_ACCEL: begin
            sel_id = MSPE_ID_ANG_ACCEL;
            sel_len = MSPE_LEN_3F;
         end
         default: begin
            sel_id = MSPE_ID_NORTH_EAST_DOWN_FRAME_VEL;
            sel_len = MSPE_LEN_3F;
         end
      endcase
   end

   // a request is taken only while idle; one that comes while busy is dropped
   assign do_capture = (state == MSPE_IDLE) && start;

   // picker offset: zero at capture, else the byte after the one being accepted
   // fetching one ahead lets the next byte leave on the edge that accepts this one
   assign fetch_idx = do_capture ? 6'h00 : byte_idx + 6'h01;

   // picker source: live fields on the capture cycle, the frozen snapshot after it
   // byte 0 then leaves with the very words that the snapshot takes
   always_comb begin
      pick_src = snap;
      if (do_capture) begin
         pick_src = field_word;
      end
   end

   // byte picker reads the chosen source
   mspe_byte_mux u_mux (
      .word_in(pick_src),
      .byte_index(fetch_idx),
      .byte_out(mux_byte)
   );

   // next-state logic of the framer
   always_comb begin
      next_state = state;
      next_snap = snap;
      next_byte_idx = byte_idx;
      next_pkt_id = pkt_id;
      next_pkt_len = pkt_len;
      next_busy = busy;
      next_out_valid = out_valid;
      next_out_data = out_data;
      next_out_last = out_last;
      case (state)
         MSPE_IDLE: begin
            // capture: byte 0 is registered together with id and length
            if (start) begin
               next_snap = field_word; // frozen so the packet stays coherent
               next_pkt_id = sel_id;
               next_pkt_len = sel_len;
               next_byte_idx = 6'h00;
               next_busy = 1'b1;
               next_out_valid = 1'b1;
               next_out_data = mux_byte;
               next_out_last = 1'b0;
               next_state = MSPE_SEND;
            end
         end
         MSPE_SEND: begin
            // the byte stands until the sink takes it
            if (out_ready) begin
               if (out_last) begin
                  // payload done, length equals field bytes
                  next_out_valid = 1'b0;
                  next_out_last = 1'b0;
                  next_busy = 1'b0;
                  next_state = MSPE_IDLE;
               end else begin
                  // advance; last marks the offset one below the length
                  next_byte_idx = fetch_idx;
                  next_out_data = mux_byte;
                  next_out_last = ({2'b00, fetch_idx} == pkt_len - 8'h01);
               end
            end
         end
         default: begin
            // unused state code: back to idle with the outputs quiet
            next_state = MSPE_IDLE;
            next_busy = 1'b0;
            next_out_valid = 1'b0;
            next_out_last = 1'b0;
         end
      endcase
   end

   // host writes to these read-only ids change nothing and are flagged;
   // the reject path never touches the framer, so a packet in flight is not disturbed
   always_comb begin
      next_write_reject = host_write && (host_write_id >= MSPE_ID_NORTH_EAST_DOWN_FRAME_VEL)
         && (host_write_id <= MSPE_ID_ANG_ACCEL);
   end

   // framer registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= MSPE_IDLE;
         // snapshot cleared so no stale words leak into a later packet
         for (int i = 0; i < MSPE_MAX_FIELDS; i++) begin
            snap[i] <= 32'h00000000;
         end
         byte_idx <= MSPE_LAST_BYTE_RESET;
         pkt_id <= 8'h00;
         pkt_len <= 8'h00;
         busy <= 1'b0;
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_last <= 1'b0;
         write_reject <= 1'b0;
      end else begin
         // every output comes straight from one of these flops
         state <= next_state;
         snap <= next_snap;
         byte_idx <= next_byte_idx;
         pkt_id <= next_pkt_id;
         pkt_len <= next_pkt_len;
         busy <= next_busy;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         out_last <= next_out_last;
         write_reject <= next_write_reject;
      end
   end
endmodule

// ==== hw/mspe_pkg.sv ====
// package: packet identifiers, lengths and layout constants of the motion-state packet encoder
package mspe_pkg;
   // packet kinds, selected on the request port
   typedef enum logic [3:0] {
      MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL = 4'h0, // north/east/down velocity
      MSPE_KIND_BODY_VEL = 4'h1, // body-frame velocity
      MSPE_KIND_ACCEL = 4'h2, // acceleration incl. gravity
      MSPE_KIND_BODY_ACCEL = 4'h3, // acceleration without gravity plus g force
      MSPE_KIND_EULER = 4'h4, // roll, pitch, heading
      MSPE_KIND_QUAT = 4'h5, // quaternion
      MSPE_KIND_DIRECTION_COSINE_MATRIX = 4'h6, // direction cosine matrix
      MSPE_KIND_ANG_VEL = 4'h7, // angular velocity
      MSPE_KIND_ANG_ACCEL = 4'h8 // angular acceleration
   } mspe_kind_t;
   // packet identifiers
   localparam logic [7:0] MSPE_ID_NORTH_EAST_DOWN_FRAME_VEL = 8'h23; // 35
   localparam logic [7:0] MSPE_ID_BODY_VEL = 8'h24; // 36
   localparam logic [7:0] MSPE_ID_ACCEL = 8'h25; // 37
   localparam logic [7:0] MSPE_ID_BODY_ACCEL = 8'h26; // 38
   localparam logic [7:0] MSPE_ID_EULER = 8'h27; // 39
   localparam logic [7:0] MSPE_ID_QUAT = 8'h28; // 40
   localparam logic [7:0] MSPE_ID_DIRECTION_COSINE_MATRIX = 8'h29; // 41
   localparam logic [7:0] MSPE_ID_ANG_VEL = 8'h2a; // 42
   localparam logic [7:0] MSPE_ID_ANG_ACCEL = 8'h2b; // 43
   // payload lengths in bytes
   localparam logic [7:0] MSPE_LEN_3F = 8'h0c; // 12, three floats
   localparam logic [7:0] MSPE_LEN_4F = 8'h10; // 16, four floats
   localparam logic [7:0] MSPE_LEN_9F = 8'h24; // 36, nine floats
   // field geometry
   localparam int MSPE_FLOAT_BYTES = 4; // bytes per single-precision word
   localparam int MSPE_MAX_FIELDS = 9; // widest payload holds nine words
   localparam logic [5:0] MSPE_LAST_BYTE_RESET = 6'h00; // counter value after reset
endpackage

// ==== test/mspe_checker.sv ====
// checker: port timing and framing properties of the packet encoder
`timescale 1ns/1ps
module mspe_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire mspe_pkg::mspe_kind_t kind,
   input wire logic host_write,
   input wire logic [7:0] host_write_id,
   input wire logic out_ready,
   input wire logic busy,
   input wire logic [7:0] pkt_id,
   input wire logic [7:0] pkt_len,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic out_last,
   input wire logic write_reject
);
   import mspe_pkg::*;
   logic [7:0] n; // bytes accepted so far
   logic [7:0] next_n;
   logic take, acc;
   assign take = start && !busy;
   assign acc = out_valid && out_ready;
   // byte count, cleared on each taken request
   always_comb begin
      next_n = take ? 8'h00 : (acc ? n + 8'h01 : n);
   end
   // count register, cleared by reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         n <= 8'h00;
      end else begin
         n <= next_n;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   take_ans_a: assert property (take |=> busy && out_valid)
      else $error("no answer");
   vel_hdr_a: assert property (take && kind == MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL
      |=> pkt_id == 8'h23 && pkt_len == 8'h0c) else $error("velocity header");
   quat_hdr_a: assert property (take && kind == MSPE_KIND_QUAT
      |=> pkt_id == 8'h28 && pkt_len == 8'h10) else $error("quaternion header");
   matrix_hdr_a: assert property (take && kind == MSPE_KIND_DIRECTION_COSINE_MATRIX
      |=> pkt_id == 8'h29 && pkt_len == 8'h24) else $error("matrix header");
   byte_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
      $stable(out_data) && $stable(out_last)) else $error("byte dropped");
   hdr_stable_a: assert property (busy && !(acc && out_last) |=>
      $stable(pkt_id) && $stable(pkt_len)) else $error("header moved");
   last_end_a: assert property (acc && out_last |=> !busy && !out_valid)
      else $error("no end");
   byte_count_a: assert property (acc && out_last |-> n + 8'h01 == pkt_len)
      else $error("length");
   reject_pulse_a: assert property (host_write && host_write_id >= 8'h23 &&
      host_write_id <= 8'h2b |=> write_reject) else $error("write not refused");
   reject_quiet_a: assert property (!(host_write && host_write_id >= 8'h23 &&
      host_write_id <= 8'h2b) |=> !write_reject) else $error("spurious refusal");
   cover property (take && kind == MSPE_KIND_DIRECTION_COSINE_MATRIX);
   cover property (out_valid && !out_ready);
   cover property (start && busy);
   cover property (write_reject && busy);
endmodule
bind mspe_encoder mspe_checker u_chk (.clk(clk), .sys_rst(sys_rst), .start(start),
   .kind(kind), .host_write(host_write), .host_write_id(host_write_id),
   .out_ready(out_ready), .busy(busy), .pkt_id(pkt_id), .pkt_len(pkt_len),
   .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
   .write_reject(write_reject));

// ==== test/mspe_host_sink.sv ====
// host sink model: accepts payload bytes promptly or one in four
`timescale 1ns/1ps
module mspe_host_sink (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic slow,
   output logic out_ready
);
   logic [1:0] ph; // stall phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph <= 2'h0;
      end else begin
         ph <= ph + 2'h1;
      end
   end
   // reads lsb-first bytes at its own pace
   assign out_ready = !slow || ph == 2'h3;
endmodule

// ==== test/tb_motion_state_packet_encoder.sv ====
// testbench: all packet kinds, stalls, busy refusal and read-only writes
`timescale 1ns/1ps
module tb_motion_state_packet_encoder;
   import mspe_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, start = 1'b0, slow = 1'b0;
   logic host_write = 1'b0, out_ready, busy, out_valid, out_last, write_reject;
   logic [7:0] host_write_id = 8'h00, pkt_id, pkt_len, out_data;
   mspe_kind_t kind = MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL;
   logic [31:0] field_word [MSPE_MAX_FIELDS];
   logic [31:0] ex [MSPE_MAX_FIELDS]; // expected snapshot
   int fail_count = 0, check_count = 0;
   always #10 clk = ~clk;
   mspe_encoder u_dut (.clk(clk), .sys_rst(sys_rst), .start(start), .kind(kind),
      .field_word(field_word), .host_write(host_write), .host_write_id(host_write_id),
      .out_ready(out_ready), .busy(busy), .pkt_id(pkt_id), .pkt_len(pkt_len),
      .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
      .write_reject(write_reject));
   mspe_host_sink u_sink (.clk(clk), .sys_rst(sys_rst), .slow(slow), .out_ready(out_ready));
   task check(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one packet; start held into busy and fields changed after the snapshot
   task automatic run_pkt(input mspe_kind_t k, input logic [7:0] id,
      input logic [7:0] len, input logic s);
      int b, t, w;
      logic [7:0] exp_byte;
      slow = s;
      kind = k;
      for (w = 0; w < MSPE_MAX_FIELDS; w++) begin
         ex[w] = {id, 8'(w), 8'h5a, 8'(w * 17)};
         field_word[w] = ex[w];
      end
      start = 1'b1;
      @(posedge clk) #1;
      kind = MSPE_KIND_DIRECTION_COSINE_MATRIX;
      field_word[0] = ~ex[0];
      check(pkt_id === id && pkt_len === len, "header");
      b = 0;
      for (t = 0; b < len && t < 200; t++) begin
         if (out_valid && out_ready) begin
            exp_byte = ex[b / MSPE_FLOAT_BYTES][8 * (b % MSPE_FLOAT_BYTES) +: 8];
            check(out_data === exp_byte, "byte");
            check(out_last === (b == len - 1), "last");
            b++;
         end
         @(posedge clk) #1;
         if (t == 0) begin
            start = 1'b0;
         end
      end
      check(busy === 1'b0 && out_valid === 1'b0 && b == len, "end");
   endtask
   // writes to ids 34..44 back to back
   task automatic write_test;
      int i;
      host_write = 1'b1;
      for (i = 34; i <= 44; i++) begin
         host_write_id = 8'(i);
         @(posedge clk) #1;
         check(write_reject === (i >= 35 && i <= 43), "reject");
      end
      host_write = 1'b0;
      @(posedge clk) #1;
      check(write_reject === 1'b0, "reject pulse");
      check(busy === 1'b0 && out_valid === 1'b0 && pkt_id === 8'h2b, "state kept");
   endtask
   // refused write inside a packet, then reset in mid-packet
   task automatic reset_test;
      slow = 1'b1;
      kind = MSPE_KIND_DIRECTION_COSINE_MATRIX;
      start = 1'b1;
      @(posedge clk) #1;
      start = 1'b0;
      host_write = 1'b1;
      host_write_id = 8'h29;
      @(posedge clk) #1;
      host_write = 1'b0;
      check(write_reject === 1'b1, "write in packet");
      check(busy === 1'b1 && out_valid === 1'b1 && pkt_id === 8'h29, "packet kept");
      repeat (3) @(posedge clk);
      #1 sys_rst = 1'b1;
      @(posedge clk) #1;
      check({busy, out_valid, out_last, write_reject} === 4'h0, "reset flags");
      check({pkt_id, pkt_len, out_data} === 24'h000000, "reset values");
      sys_rst = 1'b0;
   endtask
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      run_pkt(MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL, 8'h23, 8'h0c, 1'b0);
      run_pkt(MSPE_KIND_BODY_VEL, 8'h24, 8'h0c, 1'b1);
      run_pkt(MSPE_KIND_ACCEL, 8'h25, 8'h0c, 1'b0);
      run_pkt(MSPE_KIND_BODY_ACCEL, 8'h26, 8'h10, 1'b1);
      run_pkt(MSPE_KIND_EULER, 8'h27, 8'h0c, 1'b0);
      run_pkt(MSPE_KIND_QUAT, 8'h28, 8'h10, 1'b1);
      run_pkt(MSPE_KIND_DIRECTION_COSINE_MATRIX, 8'h29, 8'h24, 1'b1);
      run_pkt(MSPE_KIND_ANG_VEL, 8'h2a, 8'h0c, 1'b0);
      run_pkt(MSPE_KIND_ANG_ACCEL, 8'h2b, 8'h0c, 1'b1);
      write_test;
      reset_test;
      run_pkt(MSPE_KIND_NORTH_EAST_DOWN_FRAME_VEL, 8'h23, 8'h0c, 1'b0);
      report_and_stop;
   end
endmodule
